// file: hw/tsr_consts.svh
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH
// timing
`define TSR_CLK_MHZ        125
`define TSR_CAL_TIME_US    1000
`define TSR_SEC_TIME_MS    1000
`define TSR_HALT_SHORT_S   5'd2
`define TSR_HALT_LONG_S    5'd20
`define TSR_SEC_PER_MIN    16'd60
`define TSR_LIMIT_HOLD     8'hff
`define TSR_DEB_N          2'd2
`define TSR_UNDEB_TH       8'h0f
`define TSR_P_AUTO_MIN     4'h7
`define TSR_TGT_SHIFT      3
`define TSR_BOUND_SHIFT    3
// register byte addresses
`define TSR_A_PRODUCT      8'h00
`define TSR_A_VERSION      8'h01
`define TSR_A_FLAGS        8'h10
`define TSR_A_MOVE         8'h41
`define TSR_A_CNT_L        8'h42
`define TSR_A_CNT_H        8'h43
`define TSR_A_BASE_L       8'h83
`define TSR_A_BASE_H       8'h84
`define TSR_A_TLVL_L       8'h90
`define TSR_A_TLVL_H       8'h91
`define TSR_A_MULT         8'hc4
`define TSR_A_GAIN         8'hc5
`define TSR_A_CFG0         8'hc6
`define TSR_A_CFG1         8'hc7
`define TSR_A_CFG2         8'hc8
`define TSR_A_TARGET       8'hc9
`define TSR_A_SLEEP        8'hca
`define TSR_A_NEAR_TH      8'hcb
`define TSR_A_CONTACT_TH   8'hcc
`define TSR_A_MOTION_TH    8'hcd
`define TSR_A_LIMIT        8'hce
// field positions
`define TSR_C0_RESYNC      5
`define TSR_C0_RECAL       4
`define TSR_C0_BOTH_DIR    3
`define TSR_C1_MINUTES     7
`define TSR_C2_LONG_HOLD   7
`define TSR_C2_AUTO_ACT    5
`define TSR_C2_LATE_REL    3
`define TSR_C2_PARTIAL     2
`define TSR_C2_AUTO_OFF    1
`define TSR_FL_RESET       3
`define TSR_UI_LATCH       3'b001
`define TSR_UI_I2C_MIN     3'b101
`define TSR_MOV_NORMAL     2'b00
`define TSR_MOV_LATCHED    2'b10
`define TSR_MOV_WITH_ACT   2'b11
// reset values
`define TSR_CFG_RST        8'h00
`define TSR_TARGET_RST     8'h96
`define TSR_UNMAPPED       8'h00
`endif

// file: hw/tsr_pkg.sv
package tsr_pkg;
`include "tsr_consts.svh"
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRB, ST_ACK, ST_RDB, ST_RACK} tsr_i2c_st_t;

   typedef struct packed {
      logic [2:0]  scl_sync;
      logic [2:0]  sda_sync;
      logic        scl_f;
      logic        sda_f;
      tsr_i2c_st_t st;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic        rw;
      logic        ptr_phase;
      logic [7:0]  ptr;
      logic        sda_oe;
      logic [7:0]  cfg0, cfg1, cfg2, target, sleep, near_th, contact_th, motion_th, limit, mult, gain;
      logic [15:0] counts, baseline, prox_lvl, touch_lvl;
      logic [7:0]  move_level, move_acc, win_cnt;
      logic        move_seen;
      logic        move_f, latch_f, prox_f, touch_f, reset_f, busy_f, halt_f, lp_f;
      logic [1:0]  prox_deb, touch_deb;
      logic [26:0] sec_div;
      logic [4:0]  halt_sec;
      logic [15:0] hold_sec;
      logic [19:0] cal_cnt;
      logic        powerup, auto_act, act_o, mov_o;
   } tsr_state_t;
endpackage

// file: hw/tsr_regbank.sv
// How it works
// - movement flag bit 7 sets on each movement, clears when movement stops
// - latch bit 6 sets on movement with latch UI, clears only on time-out
// - near flag bit 5 follows threshold; freeze bit 1 also on raw contact
// - contact flag bit 4 drives activation in every UI; latch bit 6 also does with the latch UI
// - reset indicator bit 3 set on hard reset, host clears it
// - calibration-busy bit 2 high while the operating point is searched
// - low-power bit 0 only with nonzero sleep period and no interaction
// - 8-bit movement level is the pulse average over a sample window
// - baseline drifts toward counts, frozen while detection is active
// - resync bit loads baseline with counts, recalibrates if outside boundary
// - recalibrate bit forces calibration and clears itself when done
// - direction bit picks one-sided or two-sided near detection
// - unit bit selects minutes or seconds for the resync limit
// - config1 fields select movement output type and user interface
// - freeze held 2 s or 20 s without movement, movement restarts timer
// - auto activation at power-up when enabled, partial and P above 7
// - late release drops contact only at half the contact level
// - auto-calibration off: only the command calibrates, time-out just resyncs
// - calibration aims counts at target; host keeps target at most 1600
// - near level is baseline times setting over 256, locked at calibration
// - contact level computed alike; setting 15 or more skips debounce
// - resync limit 1..254 units, 0xff or 0 switches the limit off
`timescale 1ns/1ps
`include "tsr_consts.svh"
module tsr_regbank #(
   parameter logic [6:0]  DEV_ADDR    = 7'h44,  // arbitrary bus address
   parameter logic [7:0]  PRODUCT_ID  = 8'h5a,  // arbitrary value
   parameter logic [7:0]  VERSION_ID  = 8'h07,  // arbitrary value
   parameter int          SEC_CYCLES  = `TSR_SEC_TIME_MS * 1000 * `TSR_CLK_MHZ,
   parameter int          CAL_CYCLES  = `TSR_CAL_TIME_US * `TSR_CLK_MHZ
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_scl,
   input  wire logic        i_sda_i,
   output logic             o_sda_o,
   output logic             o_sda_oe,
   input  wire logic        i_sample_valid,
   input  wire logic [15:0] i_counts,
   input  wire logic        i_movement_pulse,
   output logic             o_activation,
   output logic             o_movement,
   output logic             o_low_power
);
   tsr_pkg::tsr_state_t s_r;
   tsr_pkg::tsr_state_t s_nxt;

   localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);
   localparam logic [19:0] CAL_LAST = 20'(CAL_CYCLES - 1);

   // register read mux, unmapped bytes read zero
   function automatic logic [7:0] rd_byte(input tsr_pkg::tsr_state_t s, input logic [7:0] a);
      logic [7:0] d;
      d = `TSR_UNMAPPED;
      case (a)
         `TSR_A_PRODUCT:    d = PRODUCT_ID;
         `TSR_A_VERSION:    d = VERSION_ID;
         `TSR_A_FLAGS:      d = {s.move_f, s.latch_f, s.prox_f, s.touch_f,
                                 s.reset_f, s.busy_f, s.halt_f, s.lp_f};
         `TSR_A_MOVE:       d = s.move_level;
         `TSR_A_CNT_L:      d = s.counts[7:0];
         `TSR_A_CNT_H:      d = s.counts[15:8];
         `TSR_A_BASE_L:     d = s.baseline[7:0];
         `TSR_A_BASE_H:     d = s.baseline[15:8];
         `TSR_A_TLVL_L:     d = s.touch_lvl[7:0];
         `TSR_A_TLVL_H:     d = s.touch_lvl[15:8];
         `TSR_A_MULT:       d = s.mult;
         `TSR_A_GAIN:       d = s.gain;
         `TSR_A_CFG0:       d = s.cfg0;
         `TSR_A_CFG1:       d = s.cfg1;
         `TSR_A_CFG2:       d = s.cfg2;
         `TSR_A_TARGET:     d = s.target;
         `TSR_A_SLEEP:      d = s.sleep;
         `TSR_A_NEAR_TH:    d = s.near_th;
         `TSR_A_CONTACT_TH: d = s.contact_th;
         `TSR_A_MOTION_TH:  d = s.motion_th;
         `TSR_A_LIMIT:      d = s.limit;
         default:           d = `TSR_UNMAPPED;
      endcase
      return d;
   endfunction

   // whole next-state: bus slave, host writes, sensing and timers
   always_comb
   begin
      logic        scl_n, sda_n, scl_rise, scl_fall, start, stop, wr_en;
      logic [7:0]  wdata, rbyte;
      logic [16:0] delta;
      logic [15:0] mag, tgt, off, lim_sec;
      logic        below, prox_hit, touch_hit, undeb, sec_tick, to_evt, out_bound;
      logic        cal_req, base_load, pulse;
      logic [4:0]  hold_lim;
      logic [23:0] p_prod, t_prod;
      scl_n = 1'b1; sda_n = 1'b1; scl_rise = 1'b0; scl_fall = 1'b0; start = 1'b0; stop = 1'b0;
      wr_en = 1'b0; wdata = 8'h00; rbyte = 8'h00; delta = 17'h00000; mag = 16'h0000;
      tgt = 16'h0000; off = 16'h0000; lim_sec = 16'h0000; below = 1'b0; prox_hit = 1'b0;
      touch_hit = 1'b0; undeb = 1'b0; sec_tick = 1'b0; to_evt = 1'b0; out_bound = 1'b0;
      cal_req = 1'b0; base_load = 1'b0; pulse = i_movement_pulse; hold_lim = 5'h00;
      p_prod = 24'h000000; t_prod = 24'h000000;
      s_nxt = s_r;

      // pin synchronisers; a level counts once stages two and three agree
      s_nxt.scl_sync = {s_r.scl_sync[1:0], i_scl};
      s_nxt.sda_sync = {s_r.sda_sync[1:0], i_sda_i};
      scl_n = (s_r.scl_sync[1] == s_r.scl_sync[2]) ? s_r.scl_sync[2] : s_r.scl_f;
      sda_n = (s_r.sda_sync[1] == s_r.sda_sync[2]) ? s_r.sda_sync[2] : s_r.sda_f;
      s_nxt.scl_f = scl_n;
      s_nxt.sda_f = sda_n;
      scl_rise = scl_n & ~s_r.scl_f;
      scl_fall = ~scl_n & s_r.scl_f;
      start = s_r.scl_f & scl_n & s_r.sda_f & ~sda_n;
      stop  = s_r.scl_f & scl_n & ~s_r.sda_f & sda_n;

      // byte-wide slave: address, pointer byte, then auto-incrementing data
      if (start)
      begin
         s_nxt.st = tsr_pkg::ST_ADDR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.ptr_phase = 1'b1;
         s_nxt.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         s_nxt.st = tsr_pkg::ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end
      else
      begin
         case (s_r.st)
            tsr_pkg::ST_IDLE: ;
            tsr_pkg::ST_ADDR, tsr_pkg::ST_WRB:
            begin
               if (scl_rise)
               begin
                  s_nxt.shreg = {s_r.shreg[6:0], sda_n};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end
               else if (scl_fall && s_r.bitcnt == 4'h8)
               begin
                  s_nxt.st = tsr_pkg::ST_ACK;
                  s_nxt.sda_oe = 1'b1;
                  if (s_r.st == tsr_pkg::ST_ADDR)
                  begin
                     s_nxt.rw = s_r.shreg[0];
                     if (s_r.shreg[7:1] != DEV_ADDR)
                     begin
                        s_nxt.st = tsr_pkg::ST_IDLE;  // not ours, stay off the line
                        s_nxt.sda_oe = 1'b0;
                     end
                  end
                  else if (s_r.ptr_phase)
                  begin
                     s_nxt.ptr = s_r.shreg;
                     s_nxt.ptr_phase = 1'b0;
                  end
                  else
                  begin
                     wr_en = 1'b1;
                     wdata = s_r.shreg;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end
               end
            end
            tsr_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = tsr_pkg::ST_WRB;
                  if (s_r.rw)
                  begin
                     rbyte = rd_byte(s_r, s_r.ptr);
                     s_nxt.shreg = rbyte;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                     s_nxt.sda_oe = ~rbyte[7];
                     s_nxt.st = tsr_pkg::ST_RDB;
                  end
               end
            end
            tsr_pkg::ST_RDB:
            begin
               if (scl_fall)
               begin
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                  s_nxt.sda_oe = ~s_r.shreg[6];
                  if (s_r.bitcnt == 4'h7)
                  begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = tsr_pkg::ST_RACK;
                  end
               end
            end
            tsr_pkg::ST_RACK:
               if (scl_rise)
                  s_nxt.st = sda_n ? tsr_pkg::ST_IDLE : tsr_pkg::ST_ACK;
            default: s_nxt.st = tsr_pkg::ST_IDLE;
         endcase
      end

      // host register writes; hardware-owned bits are never written here
      if (wr_en)
      begin
         case (s_r.ptr)
            `TSR_A_FLAGS:      if (!wdata[`TSR_FL_RESET]) s_nxt.reset_f = 1'b0;
            `TSR_A_MULT:       s_nxt.mult = wdata;
            `TSR_A_GAIN:       s_nxt.gain = wdata;
            `TSR_A_CFG0:       s_nxt.cfg0 = wdata;
            `TSR_A_CFG1:       s_nxt.cfg1 = wdata;
            `TSR_A_CFG2:       s_nxt.cfg2 = wdata;
            `TSR_A_TARGET:     s_nxt.target = wdata;
            `TSR_A_SLEEP:      s_nxt.sleep = wdata;
            `TSR_A_NEAR_TH:    s_nxt.near_th = wdata;
            `TSR_A_CONTACT_TH: s_nxt.contact_th = wdata;
            `TSR_A_MOTION_TH:  s_nxt.motion_th = wdata;
            `TSR_A_LIMIT:      s_nxt.limit = wdata;
            default: ;
         endcase
      end

      // one-second enable shared by both no-movement timers
      sec_tick = (s_r.sec_div == SEC_LAST);
      s_nxt.sec_div = sec_tick ? 27'h0000000 : s_r.sec_div + 27'h0000001;

      // movement flag, latch and intensity window; a pulse beats the clear
      if (i_sample_valid)
      begin
         s_nxt.move_f = s_r.move_seen | pulse;
         s_nxt.move_seen = 1'b0;
         s_nxt.win_cnt = s_r.win_cnt + 8'h01;
         if (s_r.move_acc != 8'hff && (s_r.move_seen | pulse))
            s_nxt.move_acc = s_r.move_acc + 8'h01;
         if (s_r.win_cnt == 8'hff)
         begin
            s_nxt.move_level = s_nxt.move_acc;
            s_nxt.move_acc = 8'h00;
         end
      end
      else if (pulse)
      begin
         s_nxt.move_seen = 1'b1;
         s_nxt.move_f = 1'b1;
      end
      if (pulse && s_r.cfg1[2:0] == `TSR_UI_LATCH)
         s_nxt.latch_f = 1'b1;

      // detection on each sample; counts below baseline are the active side
      delta = {1'b0, s_r.baseline} - {1'b0, i_counts};
      below = ~delta[16];
      mag = below ? delta[15:0] : 16'(-delta);
      prox_hit = (below || s_r.cfg0[`TSR_C0_BOTH_DIR]) && mag >= s_r.prox_lvl;
      touch_hit = below && (mag >= s_r.touch_lvl ||
                  (s_r.touch_f && s_r.cfg2[`TSR_C2_LATE_REL] && mag >= {1'b0, s_r.touch_lvl[15:1]}));
      undeb = s_r.contact_th >= `TSR_UNDEB_TH;
      if (i_sample_valid && !s_r.busy_f)
      begin
         s_nxt.counts = i_counts;
         s_nxt.prox_deb = !prox_hit ? 2'd0 : (s_r.prox_deb == `TSR_DEB_N) ? s_r.prox_deb : s_r.prox_deb + 2'd1;
         s_nxt.touch_deb = !touch_hit ? 2'd0 : (s_r.touch_deb == `TSR_DEB_N) ? s_r.touch_deb : s_r.touch_deb + 2'd1;
         s_nxt.prox_f = (s_nxt.prox_deb == `TSR_DEB_N);
         s_nxt.touch_f = (undeb ? touch_hit : s_nxt.touch_deb == `TSR_DEB_N) | s_r.auto_act;
         s_nxt.halt_f = s_nxt.prox_f | touch_hit;
         if (!s_r.halt_f && s_r.baseline != i_counts)  // slow drift, one count per sample
            s_nxt.baseline = below ? s_r.baseline - 16'h0001 : s_r.baseline + 16'h0001;
      end

      // no-movement hold timer, restarted by movement
      hold_lim = (s_r.cfg2[`TSR_C2_LONG_HOLD] && s_r.cfg1[2:0] >= `TSR_UI_I2C_MIN) ?
                 `TSR_HALT_LONG_S : `TSR_HALT_SHORT_S;
      lim_sec = {8'h00, s_r.limit} * (s_r.cfg1[`TSR_C1_MINUTES] ? `TSR_SEC_PER_MIN : 16'h0001);
      if (pulse || !s_r.halt_f)
      begin
         s_nxt.halt_sec = 5'h00;
         s_nxt.hold_sec = 16'h0000;
      end
      else if (sec_tick)
      begin
         s_nxt.halt_sec = s_r.halt_sec + 5'h01;
         s_nxt.hold_sec = s_r.hold_sec + 16'h0001;
         to_evt = (s_nxt.halt_sec >= hold_lim) ||
                  (s_r.limit != `TSR_LIMIT_HOLD && s_r.limit != 8'h00 && s_nxt.hold_sec >= lim_sec);
      end

      // boundary around the calibration target, an eighth of the target each side
      tgt = 16'({s_r.target, {`TSR_TGT_SHIFT{1'b0}}});
      off = (i_counts > tgt) ? i_counts - tgt : tgt - i_counts;
      out_bound = off > (tgt >> `TSR_BOUND_SHIFT);

      // resync command, time-out resync and recalibration requests
      if (s_r.cfg0[`TSR_C0_RESYNC] || to_evt)
      begin
         base_load = 1'b1;
         s_nxt.cfg0[`TSR_C0_RESYNC] = 1'b0;
         cal_req = out_bound && !s_r.cfg2[`TSR_C2_AUTO_OFF];
      end
      if (to_evt)
      begin
         s_nxt.latch_f = 1'b0;
         s_nxt.auto_act = 1'b0;
      end
      if (s_r.cfg0[`TSR_C0_RECAL] && !s_r.busy_f)
         cal_req = 1'b1;
      if (base_load)
      begin
         s_nxt.baseline = i_counts;
         s_nxt.counts = i_counts;
         s_nxt.prox_deb = 2'd0;
         s_nxt.touch_deb = 2'd0;
         s_nxt.prox_f = 1'b0;
         s_nxt.touch_f = s_nxt.auto_act;
         s_nxt.halt_f = 1'b0;
      end

      // calibration: levels are computed once and held until the next run
      if (cal_req && !s_r.busy_f)
      begin
         s_nxt.busy_f = 1'b1;
         s_nxt.cal_cnt = 20'h00000;
      end
      else if (s_r.busy_f)
      begin
         s_nxt.cal_cnt = s_r.cal_cnt + 20'h00001;
         if (s_r.cal_cnt >= CAL_LAST)
         begin
            p_prod = 24'(i_counts) * 24'(s_r.near_th);
            t_prod = 24'(i_counts) * 24'(s_r.contact_th);
            s_nxt.busy_f = 1'b0;
            s_nxt.cfg0[`TSR_C0_RECAL] = wr_en && s_r.ptr == `TSR_A_CFG0 && wdata[`TSR_C0_RECAL];
            s_nxt.baseline = i_counts;
            s_nxt.counts = i_counts;
            s_nxt.prox_lvl = p_prod[23:8];
            s_nxt.touch_lvl = t_prod[23:8];
            s_nxt.prox_deb = 2'd0;
            s_nxt.touch_deb = 2'd0;
            s_nxt.prox_f = 1'b0;
            s_nxt.halt_f = 1'b0;
            s_nxt.powerup = 1'b0;
            if (s_r.powerup && s_r.cfg2[`TSR_C2_AUTO_ACT] && s_r.cfg2[`TSR_C2_PARTIAL] &&
                s_r.mult[3:0] > `TSR_P_AUTO_MIN)
               s_nxt.auto_act = 1'b1;
            s_nxt.touch_f = s_nxt.auto_act;
         end
      end

      // low power only from the sleep period and with no interaction
      s_nxt.lp_f = (s_r.sleep != 8'h00) && !s_nxt.prox_f && !s_nxt.touch_f && !s_nxt.busy_f;

      // pin outputs per user interface and movement output type
      s_nxt.act_o = s_nxt.touch_f | (s_nxt.latch_f & (s_r.cfg1[2:0] == `TSR_UI_LATCH));
      case (s_r.cfg1[4:3])
         `TSR_MOV_LATCHED:  s_nxt.mov_o = s_nxt.latch_f | s_nxt.move_f;
         `TSR_MOV_WITH_ACT: s_nxt.mov_o = s_nxt.move_f | s_nxt.touch_f;
         default:           s_nxt.mov_o = s_nxt.move_f;
      endcase
   end

   // state register; power-up starts a calibration and marks the reset
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s_r <= '0;
         s_r.scl_sync <= 3'h7;
         s_r.sda_sync <= 3'h7;
         s_r.scl_f <= 1'b1;
         s_r.sda_f <= 1'b1;
         s_r.st <= tsr_pkg::ST_IDLE;
         s_r.target <= `TSR_TARGET_RST;
         s_r.reset_f <= 1'b1;
         s_r.busy_f <= 1'b1;
         s_r.powerup <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign o_sda_o = 1'b0;  // open drain: only ever pulls low
   assign o_sda_oe = s_r.sda_oe;
   assign o_activation = s_r.act_o;
   assign o_movement = s_r.mov_o;
   assign o_low_power = s_r.lp_f;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence cal_start_s;
      $rose(s_r.busy_f);
   endsequence

   a_busy_min_len: assert property (cal_start_s |-> s_r.busy_f[*8])
      else $error("calibration busy ended too early");
   a_recal_self_clear: assert property ($fell(s_r.busy_f) |-> !s_r.cfg0[`TSR_C0_RECAL])
      else $error("recalibrate bit left set after calibration");
   a_lp_only_idle: assert property (s_r.lp_f |-> s_r.sleep != 8'h00 && !s_r.prox_f && !s_r.touch_f)
      else $error("low power flag with interaction or no sleep period");
   a_halt_covers_near: assert property (s_r.prox_f |-> s_r.halt_f)
      else $error("near flag without baseline freeze");
   a_base_frozen: assert property (s_r.halt_f ##1 s_r.halt_f |-> $stable(s_r.baseline))
      else $error("baseline moved while frozen");
   a_move_sets_flag: assert property (i_movement_pulse |=> s_r.move_f)
      else $error("movement pulse did not set movement flag");
   a_latch_needs_ui: assert property ($rose(s_r.latch_f) |->
      $past(s_r.cfg1[2:0]) == `TSR_UI_LATCH && $past(i_movement_pulse))
      else $error("latch set without latch interface and movement");
   a_reset_no_reset: assert property (!$rose(s_r.reset_f))
      else $error("reset indicator set without hard reset");
   a_touch_drives_act: assert property (s_r.touch_f |-> o_activation)
      else $error("contact flag not on activation output");
endmodule

// file: verification/touch_sensor_register_map_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) \
   begin err_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module touch_sensor_register_map_bench;
   logic        i_clk = 1'b0;
   logic        sv = 1'b0;
   logic        mv = 1'b0;
   logic        i_rstn, mv_en, scl, sda, sdo, act, mov, lp, oe;
   logic [15:0] cnt, w, w2;
   logic [7:0]  d;
   int          err_count, comparisons;
   int          m [256];
   always #4 i_clk = ~i_clk;
   tsr_host host (.i_clk(i_clk), .i_sda_oe(oe), .i_sda_o(sdo), .o_scl(scl), .o_sda(sda));
   tsr_regbank #(.SEC_CYCLES(50), .CAL_CYCLES(20)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl),
      .i_sda_i(sda), .o_sda_o(sdo), .o_sda_oe(oe), .i_sample_valid(sv), .i_counts(cnt),
      .i_movement_pulse(mv), .o_activation(act), .o_movement(mov), .o_low_power(lp));
   // a count sample every ten clocks, movement rides on it
   always
   begin
      repeat (9) @(negedge i_clk);
      sv = 1'b1;
      mv = mv_en;
      @(negedge i_clk);
      sv = 1'b0;
      mv = 1'b0;
   end
   task automatic finish_test();
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wrm(input int a, input int v);
      m[a] = v;
      host.wr(a[7:0], v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      host.rd(a, v[7:0]);
      host.rd(a + 8'h01, v[15:8]);
   endtask
   // bounded wait on the activation output
   task automatic wt_act(input logic v);
      int i;
      i = 0;
      while (act !== v && i < 400)
      begin
         @(negedge i_clk);
         i++;
      end
      if (act !== v)
      begin
         err_count++;
         finish_test();
      end
   endtask
   initial
   begin
      void'($urandom(32'hef6c));
      {i_rstn, mv_en, err_count, comparisons} = '0;
      cnt = 16'd1200;
      repeat (5) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (30) @(negedge i_clk);
      host.rd(8'h00, d);
      `CHK(d, 8'h5a)
      host.rd(8'h10, d);
      `CHK(d & 8'h0c, 8'h08)
      host.wr(8'h10, 8'h00);
      host.rd(8'h10, d);
      `CHK(d[3], 1'b0)
      host.wr(8'h20, 8'h5a);
      host.rd(8'h20, d);
      `CHK(d, 8'h00)
      // random settings; target kept low and resync limit switched off
      for (int a = 8'hc4; a <= 8'hce; a++)
         if (a != 8'hc6)
            wrm(a, (a == 8'hc9) ? $urandom % 200 : (a == 8'hce) ? 8'hff : $urandom % 256);
      for (int a = 8'hc4; a <= 8'hce; a++)
         if (a != 8'hc6)
         begin
            host.rd(a[7:0], d);
            `CHK(d, m[a][7:0])
         end
      wrm(8'hc7, 0);
      wrm(8'hc8, 0);
      wrm(8'hc9, 8'h96);
      wrm(8'hca, 1);
      wrm(8'hcb, 8);
      wrm(8'hcc, 8);
      host.wr(8'hc6, 8'h10);
      host.rd(8'hc6, d);
      `CHK(d[4], 1'b0)
      rd16(8'h90, w);
      `CHK(w, 16'(1200 * m[8'hcc] / 256))
      mv_en = 1'b1;
      repeat (25) @(negedge i_clk);
      `CHK(mov, 1'b1)
      mv_en = 1'b0;
      repeat (25) @(negedge i_clk);
      `CHK(mov, 1'b0)
      `CHK(lp, 1'b1)
      // touch with movement kept up so the freeze timer restarts
      mv_en = 1'b1;
      cnt = 16'd1100;
      wt_act(1'b1);
      `CHK(lp, 1'b0)
      host.rd(8'h10, d);
      `CHK(d & 8'h32, 8'h32)
      rd16(8'h83, w);
      rd16(8'h83, w2);
      `CHK(w2, w)
      host.wr(8'hc6, 8'h20);
      wt_act(1'b0);
      rd16(8'h83, w);
      `CHK(w, 16'd1100)
      // a full window with a pulse on every sample saturates the level
      repeat (5200) @(negedge i_clk);
      host.rd(8'h41, d);
      `CHK(d, 8'hff)
      host.wr(8'hc7, 8'h01);
      host.rd(8'h10, d);
      `CHK(d[6], 1'b1)
      `CHK(act, 1'b1)
      mv_en = 1'b0;
      `CHK(host.nak, 0)
      // hard reset in mid-run must raise the indicator again
      i_rstn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (30) @(negedge i_clk);
      host.rd(8'h10, d);
      `CHK(d & 8'h0c, 8'h08)
      host.rd(8'hc9, d);
      `CHK(d, 8'h96)
      finish_test();
   end
endmodule

// file: verification/tsr_host.sv
`timescale 1ns/1ps
module tsr_host (
   input  wire logic i_clk,
   input  wire logic i_sda_oe,
   input  wire logic i_sda_o,
   output logic      o_scl,
   output logic      o_sda
);
   logic drv;
   int   nak;
   // open-drain line: pull-up unless either side pulls low
   assign o_sda = drv & (~i_sda_oe | i_sda_o);
   initial o_scl = 1'b1;
   initial drv = 1'b1;
   initial nak = 0;
   // eight clocks a phase keeps scl high and low above six
   task automatic ph();
      repeat (8) @(negedge i_clk);
   endtask
   // small gap so sda never moves in the same cycle as scl
   task automatic q();
      repeat (2) @(negedge i_clk);
   endtask
   task automatic bx(input logic b, output logic r);
      q();
      drv = b;
      ph();
      o_scl = 1'b1;
      ph();
      r = o_sda;
      o_scl = 1'b0;
   endtask
   task automatic start();
      q();
      drv = 1'b1;
      ph();
      o_scl = 1'b1;
      ph();
      drv = 1'b0;
      ph();
      o_scl = 1'b0;
   endtask
   task automatic stop();
      q();
      drv = 1'b0;
      ph();
      o_scl = 1'b1;
      ph();
      drv = 1'b1;
      ph();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic n, output logic [7:0] rx);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bx(tx[i], r);
         rx[i] = r;
      end
      bx(n, r);
      if (n && r)
         nak++;  // line left high where the slave had to acknowledge
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      start();
      xfer({7'h44, 1'b0}, 1'b1, x);
      xfer(a, 1'b1, x);
      xfer(d, 1'b1, x);
      stop();
   endtask
   // pointer write, repeated start, one byte read then nack
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] x;
      start();
      xfer({7'h44, 1'b0}, 1'b1, x);
      xfer(a, 1'b1, x);
      start();
      xfer({7'h44, 1'b1}, 1'b1, x);
      xfer(8'hff, 1'b1, d);
      nak--;  // the final high bit is the host's own nack
      stop();
   endtask
endmodule
